// >>> rtl/cvj_regs.sv
// codec control bank: volume sync, jack driven enables, adc path control
`timescale 1ns/1ns
`default_nettype none

module cvj_regs (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // register port
    input  wire logic [cvj_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [cvj_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output var  logic [cvj_pkg::DATA_W-1:0]   reg_rdata,
    // jack detect pins and power management enables
    input  wire logic [cvj_pkg::GP_N-1:0]     gp_pin,
    input  wire logic [cvj_pkg::MASK_W-1:0]   pm_drv_en,
    // output driver enables
    output var  logic [cvj_pkg::MASK_W-1:0]   drv_en,
    // active volume settings
    output var  logic [cvj_pkg::ATT_W-1:0]    dac_l_attenuation,
    output var  logic [cvj_pkg::ATT_W-1:0]    dac_r_attenuation,
    output var  logic                         dac_l_mute,
    output var  logic                         dac_r_mute,
    output var  logic [cvj_pkg::ATT_W-1:0]    adc_l_attenuation,
    output var  logic [cvj_pkg::ATT_W-1:0]    adc_r_attenuation,
    // adc filter and rate control
    output var  logic                         hpf_first_order,
    output var  logic                         hpf_second_order,
    output var  logic [cvj_pkg::CUT_W-1:0]    highpass_cutoff_sel,
    output var  logic                         adc_oversample_sel,
    // adc sample path
    input  wire logic                         adc_in_valid,
    input  wire logic [cvj_pkg::SMP_W-1:0]    adc_l_in,
    input  wire logic [cvj_pkg::SMP_W-1:0]    adc_r_in,
    output var  logic                         adc_out_valid,
    output var  logic [cvj_pkg::SMP_W-1:0]    adc_l_out,
    output var  logic [cvj_pkg::SMP_W-1:0]    adc_r_out
);
    import cvj_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        // volume shadows and active values
        logic [ATT_W-1:0]  dac_l_pend;
        logic [ATT_W-1:0]  dac_r_pend;
        logic [ATT_W-1:0]  dac_l_act;
        logic [ATT_W-1:0]  dac_r_act;
        logic [ATT_W-1:0]  adc_l_pend;
        logic [ATT_W-1:0]  adc_r_pend;
        logic [ATT_W-1:0]  adc_l_act;
        logic [ATT_W-1:0]  adc_r_act;
        logic              dac_l_mute;
        logic              dac_r_mute;
        // jack control
        logic              jack_feature_on;
        logic [SEL_W-1:0]  jack_pin_sel;
        logic [MASK_W-1:0] jack_high_driver_mask;
        logic [MASK_W-1:0] jack_low_driver_mask;
        logic [MASK_W-1:0] drv_en;
        // adc control
        logic              highpass_on;
        logic              highpass_mode_sel;
        logic [CUT_W-1:0]  highpass_cutoff_sel;
        logic              adc_oversample_sel;
        logic              adc_r_invert;
        logic              adc_l_invert;
        // derived filter controls
        logic              hpf_first;
        logic              hpf_second;
        logic [CUT_W-1:0]  cut_eff;
        // pin synchronisers and settled levels
        logic [GP_N-1:0]   gp_s1;
        logic [GP_N-1:0]   gp_s2;
        logic [GP_N-1:0]   gp_s3;
        logic [GP_N-1:0]   gp_lvl;
        // sample path
        logic              smp_valid;
        logic [SMP_W-1:0]  smp_l;
        logic [SMP_W-1:0]  smp_r;
    } cvj_state_t;

    cvj_state_t st_r;
    cvj_state_t st_nxt;

    // sign inversion saturating the most negative code
    // because that code has no positive twin in two's complement
    function automatic logic [SMP_W-1:0] cvj_neg(input logic [SMP_W-1:0] v);
        logic [SMP_W-1:0] r;
        r = SMP_ZERO - v;
        if (v == SMP_MIN) begin
            r = SMP_MAX;
        end
        return r;
    endfunction

    logic              wr_dac_l;
    logic              wr_dac_r;
    logic              wr_adc_l;
    logic              wr_adc_r;
    logic              commit;
    logic [ATT_W-1:0]  w_att;
    logic              jack_lvl;
    logic              jack_valid;
    logic [MASK_W-1:0] jack_en;

    // write decode
    assign wr_dac_l = reg_wr && (reg_addr == OFS_DAC_L_VOL);
    assign wr_dac_r = reg_wr && (reg_addr == OFS_DAC_R_VOL);
    assign wr_adc_l = reg_wr && (reg_addr == OFS_ADC_L_VOL);
    assign wr_adc_r = reg_wr && (reg_addr == OFS_ADC_R_VOL);
    // commit bit acts as a strobe during the write and is never stored
    assign commit   = reg_wdata[VOL_COMMIT];
    assign w_att    = reg_wdata[VOL_ATT_HI:VOL_ATT_LO];

    // next state
    always_comb begin
        st_nxt = st_r;
        // pin synchroniser chain; a level counts once stages two and three agree
        // stage one may be metastable, so only stage two ever reads it
        // and a one cycle glitch never reaches the jack logic
        st_nxt.gp_s1 = gp_pin;
        st_nxt.gp_s2 = st_r.gp_s1;
        st_nxt.gp_s3 = st_r.gp_s2;
        for (int i = 0; i < GP_N; i++) begin
            if (st_r.gp_s2[i] == st_r.gp_s3[i]) begin
                st_nxt.gp_lvl[i] = st_r.gp_s3[i];
            end
        end

        // dac volume pair: shadow on plain write, both apply on commit
        // a commit copies the other side's shadow as well, so left and
        // right step in the same cycle and never drift apart audibly
        if (wr_dac_l) begin
            st_nxt.dac_l_pend = w_att;
            if (commit) begin
                st_nxt.dac_l_act = w_att;
                st_nxt.dac_r_act = st_r.dac_r_pend;
            end
        end
        if (wr_dac_r) begin
            st_nxt.dac_r_pend = w_att;
            if (commit) begin
                st_nxt.dac_r_act = w_att;
                st_nxt.dac_l_act = st_r.dac_l_pend;
            end
        end
        // adc volume pair, same scheme
        if (wr_adc_l) begin
            st_nxt.adc_l_pend = w_att;
            if (commit) begin
                st_nxt.adc_l_act = w_att;
                st_nxt.adc_r_act = st_r.adc_r_pend;
            end
        end
        if (wr_adc_r) begin
            st_nxt.adc_r_pend = w_att;
            if (commit) begin
                st_nxt.adc_r_act = w_att;
                st_nxt.adc_l_act = st_r.adc_l_pend;
            end
        end
        // code zero is digital mute on the dac side
        st_nxt.dac_l_mute = (st_nxt.dac_l_act == ATT_MUTE);
        st_nxt.dac_r_mute = (st_nxt.dac_r_act == ATT_MUTE);

        // control registers
        if (reg_wr && (reg_addr == OFS_JACK_CTL)) begin
            st_nxt.jack_feature_on = reg_wdata[JCK_ON_BIT];
            st_nxt.jack_pin_sel    = reg_wdata[JCK_SEL_HI:JCK_SEL_LO];
        end
        if (reg_wr && (reg_addr == OFS_JACK_OE)) begin
            st_nxt.jack_high_driver_mask = reg_wdata[JHI_HI:JHI_LO];
            st_nxt.jack_low_driver_mask  = reg_wdata[JLO_HI:JLO_LO];
        end
        if (reg_wr && (reg_addr == OFS_ADC_CTL)) begin
            st_nxt.highpass_on         = reg_wdata[HPF_ON_BIT];
            st_nxt.highpass_mode_sel   = reg_wdata[HPF_MODE_BIT];
            st_nxt.highpass_cutoff_sel = reg_wdata[HPF_CUT_HI:HPF_CUT_LO];
            st_nxt.adc_oversample_sel  = reg_wdata[ADC_OS_BIT];
            st_nxt.adc_r_invert        = reg_wdata[ADC_RINV_BIT];
            st_nxt.adc_l_invert        = reg_wdata[ADC_LINV_BIT];
        end

        // filter structure: bypass, first order dc block or second order
        st_nxt.hpf_first  = st_r.highpass_on
                            && !st_r.highpass_mode_sel;
        st_nxt.hpf_second = st_r.highpass_on
                            && st_r.highpass_mode_sel;
        // cutoff only reaches the filter in second order mode
        st_nxt.cut_eff = CUT_ZERO;
        if (st_r.highpass_on && st_r.highpass_mode_sel) begin
            st_nxt.cut_eff = st_r.highpass_cutoff_sel;
        end

        // driver enables: jack selected mask ored with power management
        st_nxt.drv_en = pm_drv_en | jack_en;

        // sample path with per channel sign inversion
        st_nxt.smp_valid = adc_in_valid;
        // samples hold their last value between strobes
        if (adc_in_valid) begin
            st_nxt.smp_l = adc_l_in;
            st_nxt.smp_r = adc_r_in;
            if (st_r.adc_l_invert) begin
                st_nxt.smp_l = cvj_neg(adc_l_in);
            end
            if (st_r.adc_r_invert) begin
                st_nxt.smp_r = cvj_neg(adc_r_in);
            end
        end

        // read data stands only in the cycle after the read strobe
        st_nxt.rdata = DATA_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                OFS_JACK_CTL: begin
                    st_nxt.rdata[JCK_ON_BIT]            = st_r.jack_feature_on;
                    st_nxt.rdata[JCK_SEL_HI:JCK_SEL_LO] = st_r.jack_pin_sel;
                end
                OFS_DAC_L_VOL: begin
                    st_nxt.rdata[VOL_ATT_HI:VOL_ATT_LO] = st_r.dac_l_pend;
                end
                OFS_DAC_R_VOL: begin
                    st_nxt.rdata[VOL_ATT_HI:VOL_ATT_LO] = st_r.dac_r_pend;
                end
                OFS_JACK_OE: begin
                    st_nxt.rdata[JHI_HI:JHI_LO] = st_r.jack_high_driver_mask;
                    st_nxt.rdata[JLO_HI:JLO_LO] = st_r.jack_low_driver_mask;
                end
                OFS_ADC_CTL: begin
                    st_nxt.rdata[HPF_ON_BIT]            = st_r.highpass_on;
                    st_nxt.rdata[HPF_MODE_BIT]          = st_r.highpass_mode_sel;
                    st_nxt.rdata[HPF_CUT_HI:HPF_CUT_LO] = st_r.highpass_cutoff_sel;
                    st_nxt.rdata[ADC_OS_BIT]            = st_r.adc_oversample_sel;
                    st_nxt.rdata[ADC_RINV_BIT]          = st_r.adc_r_invert;
                    st_nxt.rdata[ADC_LINV_BIT]          = st_r.adc_l_invert;
                end
                OFS_ADC_L_VOL: begin
                    st_nxt.rdata[VOL_ATT_HI:VOL_ATT_LO] = st_r.adc_l_pend;
                end
                OFS_ADC_R_VOL: begin
                    st_nxt.rdata[VOL_ATT_HI:VOL_ATT_LO] = st_r.adc_r_pend;
                end
                default: begin
                    st_nxt.rdata = DATA_ZERO;
                end
            endcase
        end
    end

    // jack detect pin selection and mask choice
    always_comb begin
        jack_lvl   = 1'b0;
        jack_valid = 1'b1;
        // level comes from the settled copy, never from the raw pin
        case (st_r.jack_pin_sel)
            JCK_SEL_PIN1: begin
                jack_lvl = st_r.gp_lvl[0];
            end
            JCK_SEL_PIN2: begin
                jack_lvl = st_r.gp_lvl[1];
            end
            JCK_SEL_PIN3: begin
                jack_lvl = st_r.gp_lvl[2];
            end
            default: begin
                jack_valid = 1'b0; // reserved code detects nothing
            end
        endcase
        jack_en = MASK_RST;
        if (st_r.jack_feature_on && jack_valid) begin
            if (jack_lvl) begin
                jack_en = st_r.jack_high_driver_mask;
            end else begin
                jack_en = st_r.jack_low_driver_mask;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r                       <= '0;
            st_r.dac_l_pend            <= ATT_RST;
            st_r.dac_r_pend            <= ATT_RST;
            st_r.dac_l_act             <= ATT_RST;
            st_r.dac_r_act             <= ATT_RST;
            st_r.adc_l_pend            <= ATT_RST;
            st_r.adc_r_pend            <= ATT_RST;
            st_r.adc_l_act             <= ATT_RST;
            st_r.adc_r_act             <= ATT_RST;
            st_r.jack_high_driver_mask <= MASK_RST;
            st_r.jack_low_driver_mask  <= MASK_RST;
            st_r.highpass_on           <= ADC_CTL_RST[HPF_ON_BIT];
            st_r.adc_oversample_sel    <= ADC_CTL_RST[ADC_OS_BIT];
            // filter leaves reset enabled in first order mode
            st_r.hpf_first             <= ADC_CTL_RST[HPF_ON_BIT];
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata           = st_r.rdata;
    assign drv_en              = st_r.drv_en;
    // active volumes and mute flags
    assign dac_l_attenuation   = st_r.dac_l_act;
    assign dac_r_attenuation   = st_r.dac_r_act;
    assign dac_l_mute          = st_r.dac_l_mute;
    assign dac_r_mute          = st_r.dac_r_mute;
    assign adc_l_attenuation   = st_r.adc_l_act;
    assign adc_r_attenuation   = st_r.adc_r_act;
    // filter and rate controls
    assign hpf_first_order     = st_r.hpf_first;
    assign hpf_second_order    = st_r.hpf_second;
    assign highpass_cutoff_sel = st_r.cut_eff;
    assign adc_oversample_sel  = st_r.adc_oversample_sel;
    // sample path
    assign adc_out_valid       = st_r.smp_valid;
    assign adc_l_out           = st_r.smp_l;
    assign adc_r_out           = st_r.smp_r;
endmodule

`default_nettype wire

// >>> pkg/cvj_pkg.sv
// package with register map, field layout and reset values of the codec control bank
package cvj_pkg;
    // register port geometry
    localparam int          ADDR_W        = 7;
    localparam int          DATA_W        = 9;
    localparam int          ATT_W         = 8;
    localparam int          SMP_W         = 24;
    localparam int          GP_N          = 3;
    localparam int          SEL_W         = 2;
    localparam int          CUT_W         = 3;
    localparam int          MASK_W        = 4;

    // register addresses
    localparam logic [6:0]  OFS_JACK_CTL  = 7'h09;
    localparam logic [6:0]  OFS_DAC_L_VOL = 7'h0b;
    localparam logic [6:0]  OFS_DAC_R_VOL = 7'h0c;
    localparam logic [6:0]  OFS_JACK_OE   = 7'h0d;
    localparam logic [6:0]  OFS_ADC_CTL   = 7'h0e;
    localparam logic [6:0]  OFS_ADC_L_VOL = 7'h0f;
    localparam logic [6:0]  OFS_ADC_R_VOL = 7'h10;

    // volume registers: commit strobe on top, attenuation below
    localparam int          VOL_COMMIT    = 8;
    localparam int          VOL_ATT_LO    = 0;
    localparam int          VOL_ATT_HI    = 7;
    localparam logic [7:0]  ATT_RST       = 8'hff;
    localparam logic [7:0]  ATT_MUTE      = 8'h00;

    // jack control register fields
    localparam int          JCK_ON_BIT    = 6;
    localparam int          JCK_SEL_LO    = 4;
    localparam int          JCK_SEL_HI    = 5;
    localparam logic [1:0]  JCK_SEL_PIN1  = 2'h0;
    localparam logic [1:0]  JCK_SEL_PIN2  = 2'h1;
    localparam logic [1:0]  JCK_SEL_PIN3  = 2'h2;

    // jack driver mask register fields
    localparam int          JHI_LO        = 4;
    localparam int          JHI_HI        = 7;
    localparam int          JLO_LO        = 0;
    localparam int          JLO_HI        = 3;
    localparam int          DRV_HP        = 0;
    localparam int          DRV_SPK       = 1;
    localparam int          DRV_AUX2      = 2;
    localparam int          DRV_AUX1      = 3;
    localparam logic [3:0]  MASK_RST      = 4'h0;

    // adc control register fields
    localparam int          HPF_ON_BIT    = 8;
    localparam int          HPF_MODE_BIT  = 7;
    localparam int          HPF_CUT_LO    = 4;
    localparam int          HPF_CUT_HI    = 6;
    localparam int          ADC_OS_BIT    = 3;
    localparam int          ADC_RINV_BIT  = 1;
    localparam int          ADC_LINV_BIT  = 0;
    localparam logic [8:0]  ADC_CTL_RST   = 9'h100;

    // zero fill values and sample extremes
    localparam logic [8:0]  DATA_ZERO     = 9'h000;
    localparam logic [2:0]  CUT_ZERO      = 3'h0;
    localparam logic [2:0]  GP_ZERO       = 3'h0;
    localparam logic [23:0] SMP_ZERO      = 24'h000000;
    localparam logic [23:0] SMP_MIN       = 24'h800000;
    localparam logic [23:0] SMP_MAX       = 24'h7fffff;
endpackage

// >>> sim/cvj_regs_props.sv
// assertion checker watching the codec control bank ports
`timescale 1ns/1ns
`default_nettype none
module cvj_regs_props (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       rst_b,
    // register port
    input wire logic [cvj_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cvj_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [cvj_pkg::DATA_W-1:0] reg_rdata,
    // driver enables
    input wire logic [cvj_pkg::MASK_W-1:0] pm_drv_en,
    input wire logic [cvj_pkg::MASK_W-1:0] drv_en,
    // volume and filter outputs
    input wire logic [cvj_pkg::ATT_W-1:0]  dac_l_attenuation,
    input wire logic [cvj_pkg::ATT_W-1:0]  dac_r_attenuation,
    input wire logic                       dac_l_mute,
    input wire logic                       dac_r_mute,
    input wire logic [cvj_pkg::ATT_W-1:0]  adc_l_attenuation,
    input wire logic                       hpf_first_order,
    input wire logic                       hpf_second_order,
    input wire logic [cvj_pkg::CUT_W-1:0]  highpass_cutoff_sel
);
    import cvj_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // a volume write with a given commit bit
    sequence s_vol_wr(a, c);
        reg_wr && reg_addr == a && reg_wdata[VOL_COMMIT] == c;
    endsequence

    // volume shadow and commit behaviour
    a_dac_r_shadow: assert property (s_vol_wr(OFS_DAC_R_VOL, 1'b0)
        |=> $stable(dac_r_attenuation)) else $error("dac right moved");
    a_dac_r_commit: assert property (s_vol_wr(OFS_DAC_R_VOL, 1'b1)
        |=> {1'b1, dac_r_attenuation} == $past(reg_wdata))
        else $error("dac right commit lost");
    a_dac_l_commit: assert property (s_vol_wr(OFS_DAC_L_VOL, 1'b1)
        |=> {1'b1, dac_l_attenuation} == $past(reg_wdata))
        else $error("dac left commit lost");
    a_adc_l_shadow: assert property (s_vol_wr(OFS_ADC_L_VOL, 1'b0)
        |=> $stable(adc_l_attenuation)) else $error("adc left moved");
    a_adc_l_commit: assert property (s_vol_wr(OFS_ADC_L_VOL, 1'b1)
        |=> {1'b1, adc_l_attenuation} == $past(reg_wdata))
        else $error("adc left commit lost");
    a_mute_code: assert property (dac_r_mute == (dac_r_attenuation == 8'h00)
        && dac_l_mute == (dac_l_attenuation == 8'h00)) else $error("mute wrong");
    a_commit_rd_zero: assert property (reg_rd && (reg_addr == OFS_DAC_R_VOL
        || reg_addr == OFS_ADC_L_VOL) |=> !reg_rdata[VOL_COMMIT])
        else $error("commit bit read back");
    // filter mode outputs and driver enables
    a_hpf_excl: assert property (!(hpf_first_order && hpf_second_order))
        else $error("both filter modes");
    a_cut_gate: assert property (!hpf_second_order
        |-> highpass_cutoff_sel == 3'h0) else $error("cutoff leaks");
    a_pm_or: assert property ($past(rst_b, 2)
        |-> (~drv_en & $past(pm_drv_en)) == 4'h0) else $error("pm enable lost");
endmodule
`default_nettype wire

// >>> sim/cvj_regs_tb_top.sv
// self-checking testbench for the codec control bank
`timescale 1ns/1ns
`default_nettype none
module cvj_regs_tb_top;
    import cvj_pkg::*;
    logic              clk, rst_b, reg_wr, reg_rd, rd_d, adc_in_valid;
    logic              dac_l_mute, dac_r_mute, hpf_first_order;
    logic              hpf_second_order, adc_oversample_sel, adc_out_valid;
    logic [6:0]        reg_addr;
    logic [8:0]        reg_wdata, reg_rdata, w;
    logic [7:0]        dac_l_attenuation, dac_r_attenuation, m, u, v;
    logic [7:0]        adc_l_attenuation, adc_r_attenuation;
    logic [3:0]        pm_drv_en, drv_en, j;
    logic [2:0]        gp_pin, highpass_cutoff_sel, g, c;
    logic [23:0]       adc_l_in, adc_r_in, adc_l_out, adc_r_out;
    logic [23:0]       rd_q[$], smp_q[$];
    int                error_cnt, num_checks;

    // device under test
    cvj_regs i_cvj_regs (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .gp_pin, .pm_drv_en, .drv_en, .dac_l_attenuation,
        .dac_r_attenuation, .dac_l_mute, .dac_r_mute, .adc_l_attenuation,
        .adc_r_attenuation, .hpf_first_order, .hpf_second_order,
        .highpass_cutoff_sel, .adc_oversample_sel, .adc_in_valid, .adc_l_in,
        .adc_r_in, .adc_out_valid, .adc_l_out, .adc_r_out);

    // compare and count
    task automatic chk(input string what, input logic [23:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // counts, verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // register bus cycles
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(24'(e));
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    // sign inversion with the most negative code saturated
    function automatic logic [23:0] neg(input logic [23:0] x);
        return (x === SMP_MIN) ? SMP_MAX : 24'(-x);
    endfunction
    task automatic smp(input logic [23:0] l, r, input logic li, ri);
        @(posedge clk);
        adc_in_valid <= 1'b1;
        adc_l_in     <= l;
        adc_r_in     <= r;
        smp_q.push_back(li ? neg(l) : l);
        smp_q.push_back(ri ? neg(r) : r);
        @(posedge clk);
        adc_in_valid <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // result watcher pops the oldest note when a result appears
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1) begin
            chk("reg_rdata", 24'(reg_rdata), rd_q.pop_front());
        end
        if (adc_out_valid === 1'b1) begin
            chk("adc_l_out", adc_l_out, smp_q.pop_front());
            chk("adc_r_out", adc_r_out, smp_q.pop_front());
        end
    end
    // watchdog
    initial begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        results();
    end
    // main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, rd_d, adc_in_valid, gp_pin, pm_drv_en} = '0;
        {reg_addr, reg_wdata, adc_l_in, adc_r_in} = '0;
        error_cnt  = 0;
        num_checks = 0;
        void'($urandom(57));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wr(7'h7f, 9'h1ff);
        rd(OFS_DAC_R_VOL, 9'h0ff);
        rd(OFS_JACK_OE, 9'h000);
        rd(OFS_ADC_L_VOL, 9'h0ff);
        rd(OFS_ADC_CTL, ADC_CTL_RST);
        rd(7'h7f, DATA_ZERO);
        $display("reset test done");
        wr(OFS_DAC_R_VOL, 9'h080);
        settle(1);
        chk("dac_r_att", 24'(dac_r_attenuation), 24'h0ff);
        rd(OFS_DAC_R_VOL, 9'h080);
        wr(OFS_DAC_L_VOL, 9'h140);
        settle(1);
        chk("dac_l_att", 24'(dac_l_attenuation), 24'h040);
        chk("dac_r_att", 24'(dac_r_attenuation), 24'h080);
        wr(OFS_DAC_R_VOL, 9'h100);
        settle(1);
        chk("dac_r_att", 24'(dac_r_attenuation), 24'h000);
        chk("dac_r_mute", 24'(dac_r_mute), 24'h1);
        rd(OFS_DAC_R_VOL, 9'h000);
        wr(OFS_DAC_L_VOL, 9'h000);
        wr(OFS_DAC_R_VOL, 9'h1ff);
        settle(1);
        chk("dac_l_att", 24'(dac_l_attenuation), 24'h000);
        chk("dac_l_mute", 24'(dac_l_mute), 24'h1);
        chk("dac_r_mute", 24'(dac_r_mute), 24'h0);
        u = 8'($urandom);
        v = 8'($urandom);
        wr(OFS_ADC_R_VOL, {1'b0, u});
        wr(OFS_ADC_L_VOL, {1'b0, v});
        settle(1);
        chk("adc_l_att", 24'(adc_l_attenuation), 24'h0ff);
        wr(OFS_ADC_L_VOL, {1'b1, v});
        settle(1);
        chk("adc_l_att", 24'(adc_l_attenuation), 24'(v));
        chk("adc_r_att", 24'(adc_r_attenuation), 24'(u));
        rd(OFS_ADC_L_VOL, {1'b0, v});
        wr(OFS_ADC_L_VOL, {1'b0, u});
        wr(OFS_ADC_R_VOL, {1'b1, v});
        settle(1);
        chk("adc_r_att", 24'(adc_r_attenuation), 24'(v));
        chk("adc_l_att", 24'(adc_l_attenuation), 24'(u));
        $display("volume test done");
        for (int k = 0; k < 4; k++) begin
            c = 3'($urandom) | 3'h1;
            w = {k[1], k[0], c, 1'($urandom), 1'b0, k[0], k[1]};
            wr(OFS_ADC_CTL, w);
            rd(OFS_ADC_CTL, w);
            settle(1);
            chk("hpf1", 24'(hpf_first_order), 24'(k == 2));
            chk("hpf2", 24'(hpf_second_order), 24'(k == 3));
            chk("cutoff", 24'(highpass_cutoff_sel), k == 3 ? 24'(c) : 24'h0);
            chk("os", 24'(adc_oversample_sel), 24'(w[3]));
            smp(SMP_MIN, 24'($urandom), k[1], k[0]);
            smp(24'($urandom), SMP_MIN, k[1], k[0]);
            settle(2);
        end
        $display("adc control test done");
        m = 8'($urandom);
        wr(OFS_JACK_OE, {1'b0, m});
        rd(OFS_JACK_OE, {1'b0, m});
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            g = 3'($urandom);
            if (k[1:0] != 2'h3) g[k[1:0]] = k[3];
            gp_pin    <= g;
            pm_drv_en <= 4'($urandom);
            wr(OFS_JACK_CTL, 9'({k[2], k[1:0], 4'h0}));
            settle(8);
            j = (k[2] && k[1:0] != 2'h3) ? (k[3] ? m[7:4] : m[3:0]) : 4'h0;
            chk("drv_en", 24'(drv_en), 24'(pm_drv_en | j));
        end
        $display("jack test done");
        results();
    end
endmodule

// checker beside the top module ports
bind cvj_regs cvj_regs_props i_cvj_regs_props (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pm_drv_en, .drv_en,
    .dac_l_attenuation, .dac_r_attenuation, .dac_l_mute, .dac_r_mute,
    .adc_l_attenuation, .hpf_first_order, .hpf_second_order,
    .highpass_cutoff_sel);
`default_nettype wire
